/* logic/ssa_alu.sv */
// execution stage for subtract, nibble swap and test-complement-mask
`timescale 1ns/10ps
`default_nettype none
// Function
// RL1 - subtract writes destination minus source back to destination
// RL2 - subtract leaves the source untouched; only destination and flags
// RL3 - difference formed by adding two's complement of source in 8 bits
// RL4 - subtract sets carry on borrow out of the byte, else clears
// RL5 - subtract sets sign when the result is negative, else clears
// RL6 - overflow set if operand signs differ and result sign equals source
// RL7 - subtract forces decimal-adjust to 1; half-carry set on nibble borrow
// RL8 - subtract opcodes 22 to 26 with their lengths and cycles
// RL9 - swap exchanges low and high nibble and writes destination
// RL10 - swap opcodes F0 and F1, two bytes, four cycles
// RL11 - swap and test-mask set zero when the result is 0
// RL12 - swap and test-mask copy result bit 7 into sign
// RL13 - test-mask result is inverted destination ANDed with source mask
// RL14 - test-mask writes neither operand, only flags
// RL15 - test-mask clears overflow, keeps carry, decimal-adjust, half-carry
// RL16 - test-mask opcodes 62 to 66 with their lengths and cycles
// RL17 - swap keeps carry, overflow, decimal-adjust and half-carry
// RL18 - subtract result negative means bit 7 of difference is one
module ssa_alu (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // request from decoder
    input wire logic req_valid,
    input wire ssa_pkg::ssa_req_t req,
    // answer to register file and flag register
    output ssa_pkg::ssa_rsp_t rsp,
    output logic rsp_valid,
    output logic rsp_illegal
);
    import ssa_pkg::*;

    ssa_dec_t dec;
    ssa_rsp_t rsp_nxt;
    logic [8:0] sum9;
    logic [4:0] low5;
    logic [7:0] diff;
    logic [7:0] swp;
    logic [7:0] test_complement_mask_op;

    ssa_decode u_dec (
        .opcode(req.opcode),
        .dec(dec)
    );

    ////////////////////////////////////////////////////////////////////////
    // datapath

    // dst + ~src + 1 in one 8-bit adder with carry out
    assign sum9 = {1'b0, req.dst} + {1'b0, ~req.src} + 9'h001; // see RL3
    assign low5 = {1'b0, req.dst[3:0]} + {1'b0, ~req.src[3:0]} + 5'h01;
    assign diff = sum9[7:0]; // see RL1
    assign swp = {req.dst[3:0], req.dst[7:4]}; // see RL9
    assign test_complement_mask_op = (~req.dst) & req.src; // see RL13

    always_comb begin
        rsp_nxt = '0;
        rsp_nxt.dec = dec;
        rsp_nxt.flags = req.flags;
        case (dec.fn)
            SSA_FN_SUB: begin
                rsp_nxt.result = diff; // see RL1
                rsp_nxt.dst_we = 1'b1; // see RL1
                rsp_nxt.src_we = 1'b0; // see RL2
                rsp_nxt.flags.c = ~sum9[8]; // see RL4
                rsp_nxt.flags.z = (diff == 8'h00);
                rsp_nxt.flags.s = diff[7]; // see RL5 RL18
                rsp_nxt.flags.v = (req.dst[7] ^ req.src[7])
                    & (diff[7] == req.src[7]); // see RL6
                rsp_nxt.flags.d = 1'b1; // see RL7
                rsp_nxt.flags.h = ~low5[4]; // see RL7
            end
            SSA_FN_SWAP: begin
                rsp_nxt.result = swp; // see RL9
                rsp_nxt.dst_we = 1'b1; // see RL9
                rsp_nxt.flags.z = (swp == 8'h00); // see RL11
                rsp_nxt.flags.s = swp[7]; // see RL12
                // c, v, d, h kept from incoming flags; see RL17
            end
            SSA_FN_TCM: begin
                rsp_nxt.result = test_complement_mask_op; // see RL13
                rsp_nxt.dst_we = 1'b0; // see RL14
                rsp_nxt.src_we = 1'b0; // see RL14
                rsp_nxt.flags.z = (test_complement_mask_op == 8'h00); // see RL11
                rsp_nxt.flags.s = test_complement_mask_op[7]; // see RL12
                rsp_nxt.flags.v = 1'b0; // see RL15
            end
            default: begin
                rsp_nxt.result = 8'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // output registers

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp <= '{result: 8'h00, dst_we: 1'b0, src_we: 1'b0,
                     flags: SSA_FLAGS_RST, dec: '0};
        end else if (clk_en) begin
            if (req_valid) begin
                rsp <= rsp_nxt;
                if (!dec.hit) begin
                    rsp.dst_we <= 1'b0;
                end
            end else begin
                rsp.dst_we <= 1'b0;
                rsp.src_we <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_illegal <= 1'b0;
        end else if (clk_en) begin
            rsp_valid <= req_valid & dec.hit;
            rsp_illegal <= req_valid & ~dec.hit;
        end
    end
endmodule
`default_nettype wire

/* logic/ssa_pkg.sv */
// package: opcodes, flag layout and timing figures of the alu block
package ssa_pkg;
    localparam int SSA_CLK_MHZ = 100;
    // opcodes
    localparam logic [7:0] SSA_OP_SUB_RR = 8'h22;
    localparam logic [7:0] SSA_OP_SUB_RIR = 8'h23;
    localparam logic [7:0] SSA_OP_SUB_GG = 8'h24;
    localparam logic [7:0] SSA_OP_SUB_GIG = 8'h25;
    localparam logic [7:0] SSA_OP_SUB_GIM = 8'h26;
    localparam logic [7:0] SSA_OP_SWP_G = 8'hF0;
    localparam logic [7:0] SSA_OP_SWP_IG = 8'hF1;
    localparam logic [7:0] SSA_OP_TCM_RR = 8'h62;
    localparam logic [7:0] SSA_OP_TCM_RIR = 8'h63;
    localparam logic [7:0] SSA_OP_TCM_GG = 8'h64;
    localparam logic [7:0] SSA_OP_TCM_GIG = 8'h65;
    localparam logic [7:0] SSA_OP_TCM_GIM = 8'h66;
    // lengths and cycle figures
    localparam logic [1:0] SSA_LEN_2 = 2'h2;
    localparam logic [1:0] SSA_LEN_3 = 2'h3;
    localparam logic [3:0] SSA_CYC_4 = 4'h4;
    localparam logic [3:0] SSA_CYC_6 = 4'h6;
    // flag reset value
    localparam logic [5:0] SSA_FLAGS_RST = 6'h00;
    // result latency of the execution stage in clk cycles
    localparam int SSA_LAT_CYC = 1;

    typedef enum logic [1:0] {
        SSA_FN_NONE = 2'b00,
        SSA_FN_SUB = 2'b01,
        SSA_FN_SWAP = 2'b10,
        SSA_FN_TCM = 2'b11
    } ssa_fn_t;

    typedef enum logic [2:0] {
        SSA_AM_WR_WR = 3'b000,
        SSA_AM_WR_IWR = 3'b001,
        SSA_AM_REG_REG = 3'b010,
        SSA_AM_REG_IREG = 3'b011,
        SSA_AM_REG_IMM = 3'b100,
        SSA_AM_REG = 3'b101,
        SSA_AM_IREG = 3'b110,
        SSA_AM_NONE = 3'b111
    } ssa_am_t;

    // c z s v d h
    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic d;
        logic h;
    } ssa_flags_t;

    typedef struct packed {
        ssa_fn_t fn;
        ssa_am_t mode;
        logic [1:0] bytes;
        logic [3:0] cycles;
        logic hit;
    } ssa_dec_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] dst;
        logic [7:0] src;
        ssa_flags_t flags;
    } ssa_req_t;

    typedef struct packed {
        logic [7:0] result;
        logic dst_we;
        logic src_we;
        ssa_flags_t flags;
        ssa_dec_t dec;
    } ssa_rsp_t;
endpackage

/* logic/ssa_decode.sv */
// opcode decoder: function, addressing form, length and cycles
`timescale 1ns/10ps
`default_nettype none
module ssa_decode (
    // opcode in
    input wire logic [7:0] opcode,
    // decoded form
    output ssa_pkg::ssa_dec_t dec
);
    import ssa_pkg::*;

    always_comb begin
        dec = '{fn: SSA_FN_NONE, mode: SSA_AM_NONE, bytes: 2'h0,
                cycles: 4'h0, hit: 1'b0};
        case (opcode)
            SSA_OP_SUB_RR: dec = '{SSA_FN_SUB, SSA_AM_WR_WR,
                SSA_LEN_2, SSA_CYC_4, 1'b1}; // see RL8
            SSA_OP_SUB_RIR: dec = '{SSA_FN_SUB, SSA_AM_WR_IWR,
                SSA_LEN_2, SSA_CYC_6, 1'b1}; // see RL8
            SSA_OP_SUB_GG: dec = '{SSA_FN_SUB, SSA_AM_REG_REG,
                SSA_LEN_3, SSA_CYC_6, 1'b1}; // see RL8
            SSA_OP_SUB_GIG: dec = '{SSA_FN_SUB, SSA_AM_REG_IREG,
                SSA_LEN_3, SSA_CYC_6, 1'b1}; // see RL8
            SSA_OP_SUB_GIM: dec = '{SSA_FN_SUB, SSA_AM_REG_IMM,
                SSA_LEN_3, SSA_CYC_6, 1'b1}; // see RL8
            SSA_OP_SWP_G: dec = '{SSA_FN_SWAP, SSA_AM_REG,
                SSA_LEN_2, SSA_CYC_4, 1'b1}; // see RL10
            SSA_OP_SWP_IG: dec = '{SSA_FN_SWAP, SSA_AM_IREG,
                SSA_LEN_2, SSA_CYC_4, 1'b1}; // see RL10
            SSA_OP_TCM_RR: dec = '{SSA_FN_TCM, SSA_AM_WR_WR,
                SSA_LEN_2, SSA_CYC_4, 1'b1}; // see RL16
            SSA_OP_TCM_RIR: dec = '{SSA_FN_TCM, SSA_AM_WR_IWR,
                SSA_LEN_2, SSA_CYC_6, 1'b1}; // see RL16
            SSA_OP_TCM_GG: dec = '{SSA_FN_TCM, SSA_AM_REG_REG,
                SSA_LEN_3, SSA_CYC_6, 1'b1}; // see RL16
            SSA_OP_TCM_GIG: dec = '{SSA_FN_TCM, SSA_AM_REG_IREG,
                SSA_LEN_3, SSA_CYC_6, 1'b1}; // see RL16
            SSA_OP_TCM_GIM: dec = '{SSA_FN_TCM, SSA_AM_REG_IMM,
                SSA_LEN_3, SSA_CYC_6, 1'b1}; // see RL16
            default: dec = '{fn: SSA_FN_NONE, mode: SSA_AM_NONE,
                bytes: 2'h0, cycles: 4'h0, hit: 1'b0};
        endcase
    end
endmodule
`default_nettype wire

/* test/ssa_rf_model.sv */
// register file model holding the two operand cells
`timescale 1ns/10ps
`default_nettype none
module ssa_rf_model (
    // clock, reset
    input wire logic clk,
    input wire logic reset_n,
    // alu traffic
    input wire logic take,
    input wire ssa_pkg::ssa_req_t req,
    input wire ssa_pkg::ssa_rsp_t rsp,
    input wire logic rsp_valid,
    output logic [7:0] dst_q,
    output logic [7:0] src_q
);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dst_q <= 8'h00;
            src_q <= 8'h00;
        end else if (take) begin
            dst_q <= req.dst;
            src_q <= req.src;
        end else if (rsp_valid) begin
            if (rsp.dst_we) dst_q <= rsp.result;
            if (rsp.src_we) src_q <= rsp.result;
        end
    end
endmodule
`default_nettype wire

/* test/ssa_alu_sva.sv */
// assertion checker for the alu execution stage
`timescale 1ns/10ps
`default_nettype none
module ssa_alu_sva (
    // clock, reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // request and answer
    input wire logic req_valid,
    input wire ssa_pkg::ssa_req_t req,
    input wire ssa_pkg::ssa_rsp_t rsp,
    input wire logic rsp_valid,
    input wire logic rsp_illegal
);
    import ssa_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic tk, sb, sw, tc;
    assign tk = clk_en && req_valid;
    assign sb = tk && req.opcode inside {[8'h22:8'h26]};
    assign sw = tk && req.opcode inside {8'hF0, 8'hF1};
    assign tc = tk && req.opcode inside {[8'h62:8'h66]};
    a_sub_diff: assert property (sb |=> rsp.dst_we &&
        rsp.result == $past(req.dst) - $past(req.src)) else $error("sub");
    a_sub_carry: assert property (sb |=>
        rsp.flags.c == ($past(req.dst) < $past(req.src))) else $error("c");
    a_sub_sdh: assert property (sb |=> rsp.flags.d &&
        rsp.flags.s == rsp.result[7] &&
        rsp.flags.h == ($past(req.dst[3:0]) < $past(req.src[3:0])))
        else $error("sdh");
    a_sub_ovf: assert property (sb |=> rsp.flags.v ==
        ($past(req.dst[7]) != $past(req.src[7]) &&
        rsp.result[7] == $past(req.src[7]))) else $error("v");
    a_swap_res: assert property (sw |=> rsp.dst_we &&
        rsp.result == {$past(req.dst[3:0]), $past(req.dst[7:4])})
        else $error("swap");
    a_zs_flags: assert property (sw || tc |=>
        rsp.flags.z == (rsp.result == 8'h00) &&
        rsp.flags.s == rsp.result[7]) else $error("zs");
    a_tcm_res: assert property (tc |=> !rsp.dst_we &&
        rsp.result == ($past(~req.dst) & $past(req.src))) else $error("tcm");
    a_keep_flags: assert property (sw || tc |=>
        {rsp.flags.c, rsp.flags.d, rsp.flags.h} == $past({req.flags.c,
        req.flags.d, req.flags.h}) && ($past(sw) || !rsp.flags.v) &&
        (!$past(sw) || rsp.flags.v == $past(req.flags.v))) else $error("k");
    a_one_pulse: assert property (rsp_valid && clk_en && !req_valid |=>
        !rsp_valid && !rsp_illegal && !rsp.dst_we) else $error("pulse");
    a_src_kept: assert property (rsp_valid |-> !rsp.src_we)
        else $error("src");
    a_freeze_hold: assert property (!clk_en |=> $stable(rsp) &&
        $stable(rsp_valid) && $stable(rsp_illegal)) else $error("freeze");
    a_bad_op: assert property (tk && !sb && !sw && !tc |=>
        rsp_illegal && !rsp_valid && !rsp.dst_we) else $error("bad");
    c_sub: cover property (sb ##1 rsp.flags.v);
    c_swap: cover property (sw);
    c_tcm_zero: cover property (tc ##1 rsp.flags.z);
endmodule
bind ssa_alu ssa_alu_sva chk (.clk(clk), .reset_n(reset_n),
    .clk_en(clk_en), .req_valid(req_valid), .req(req), .rsp(rsp),
    .rsp_valid(rsp_valid), .rsp_illegal(rsp_illegal));
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the alu execution stage
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ssa_pkg::*;
    logic clk, reset_n, clk_en, req_valid, rsp_valid, rsp_illegal, ill;
    ssa_req_t req, q;
    ssa_rsp_t rsp, e, p;
    logic [7:0] rf_dst, rf_src;
    int err_count, n_checks, seed, cyc;
    logic [7:0] ops [12] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'hF0,
        8'hF1, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66};
    logic [23:0] hc [4] = '{24'h221203, 24'h262190, 24'h62C702, 24'hF03E00};
    ssa_alu dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .req_valid(req_valid), .req(req), .rsp(rsp),
        .rsp_valid(rsp_valid), .rsp_illegal(rsp_illegal));
    ssa_rf_model rf (.clk(clk), .reset_n(reset_n),
        .take(clk_en && req_valid), .req(req), .rsp(rsp),
        .rsp_valid(rsp_valid), .dst_q(rf_dst), .src_q(rf_src));
    function automatic ssa_rsp_t model(input ssa_req_t a);
        ssa_rsp_t r;
        r = '0;
        r.flags = a.flags;
        r.dec.bytes = (a.opcode[3:0] > 4'h3) ? 2'h3 : 2'h2;
        r.dec.cycles = (a.opcode[3:0] > 4'h2 && !a.opcode[7]) ? 4'h6 : 4'h4;
        r.dst_we = a.opcode[7:4] != 4'h6;
        r.dec.hit = 1'b1;
        r.dec.fn = a.opcode[7] ? SSA_FN_SWAP
            : (a.opcode[6] ? SSA_FN_TCM : SSA_FN_SUB);
        if (a.opcode[7]) r.dec.mode = a.opcode[0] ? SSA_AM_IREG : SSA_AM_REG;
        else r.dec.mode = ssa_am_t'(a.opcode[2:0] - 3'h2);
        if (a.opcode[7:4] == 4'h2) begin
            r.result = a.dst + ~a.src + 8'h01;
            r.flags.c = a.dst < a.src;
            r.flags.v = (a.dst[7] != a.src[7]) && (r.result[7] == a.src[7]);
            r.flags.d = 1'b1;
            r.flags.h = a.dst[3:0] < a.src[3:0];
        end else if (a.opcode[7]) begin
            r.result = {a.dst[3:0], a.dst[7:4]};
        end else begin
            r.result = ~a.dst & a.src;
            r.flags.v = 1'b0;
        end
        r.flags.z = r.result == 8'h00;
        r.flags.s = r.result[7];
        return r;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        seed = 59609;
        {reset_n, clk_en, req_valid, req} = '0;
        repeat (2) @(posedge clk);
        @(negedge clk) reset_n = 1'b1;
        for (int i = 0; i < 300; i++) begin
            @(negedge clk);
            ill = i % 9 == 8;
            q.opcode = ops[4'((32'h7FFF & $random(seed)) % 12)];
            if (ill) q.opcode = {4'h1, 4'($random(seed))};
            {q.dst, q.src, q.flags} = 22'($random(seed));
            if (i < 4) {q.opcode, q.dst, q.src} = hc[i];
            e = model(q);
            p = rsp;
            req = q;
            req_valid = 1'b1;
            clk_en = i % 11 != 10;
            @(negedge clk);
            {req_valid, clk_en} = 2'b01;
            if (i % 11 == 10) begin
                chk({rsp_valid, rsp_illegal}, 2'b00);
                chk(rsp, p);
            end else begin
                if (ill) e = '{result: 8'h00, dst_we: 1'b0, src_we: 1'b0,
                    flags: q.flags, dec: '{SSA_FN_NONE, SSA_AM_NONE, 2'h0,
                    4'h0, 1'b0}};
                chk({rsp_valid, rsp_illegal}, {!ill, ill});
                chk({rsp.result, rsp.dst_we, rsp.src_we, rsp.flags},
                    {e.result, e.dst_we, e.src_we, e.flags});
                chk(rsp.dec, e.dec);
                @(negedge clk);
                chk({rf_dst, rf_src}, {e.dst_we ? e.result : q.dst,
                    q.src});
            end
        end
        $display("random operation test done");
        final_report();
    end
endmodule
`default_nettype wire
